// File: common/sfbu_pkg.sv
// constants and types shared by the status flag and bit operation unit
package sfbu_pkg;

  // ===========================================================================
  // bus geometry
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          REG_W         = 8;
  localparam int          OP_W          = 5;
  localparam int          IDX_W         = 3;
  localparam int          CNT_W         = 16;

  // ===========================================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] CMD_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] DEST_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] SRC_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] FLAGS_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] STAT_OFS  = 8'h10;

  // ===========================================================================
  // field positions
  localparam int          CMD_OP_LSB    = 0;
  localparam int          CMD_IDX_LSB   = 8;
  localparam int          STAT_ILL_BIT  = 16;

  // status flag bit positions
  localparam int          FLAG_C        = 0;
  localparam int          FLAG_Z        = 1;
  localparam int          FLAG_N        = 2;
  localparam int          FLAG_V        = 3;
  localparam int          FLAG_S        = 4;
  localparam int          FLAG_H        = 5;
  localparam int          FLAG_T        = 6;
  localparam int          FLAG_I        = 7;

  // ===========================================================================
  // reset values
  localparam logic [REG_W-1:0] FLAGS_RST  = 8'h00;
  localparam logic [REG_W-1:0] DEST_RST   = 8'h00;
  localparam logic [REG_W-1:0] SRC_RST    = 8'h00;
  localparam logic [OP_W-1:0]  OP_RST     = 5'h1f;
  localparam logic [CNT_W-1:0] CNT_RST    = 16'h0000;

  // ===========================================================================
  // operation codes
  localparam logic [OP_W-1:0] ARITH_SHIFT_RIGHT_OP   = 5'h00;
  localparam logic [OP_W-1:0] NIBBLE_SWAP_OP         = 5'h01;
  localparam logic [OP_W-1:0] FLAG_SET_BY_INDEX_OP   = 5'h02;
  localparam logic [OP_W-1:0] FLAG_CLEAR_BY_INDEX_OP = 5'h03;
  localparam logic [OP_W-1:0] BIT_TO_TRANSFER_OP     = 5'h04;
  localparam logic [OP_W-1:0] TRANSFER_TO_BIT_OP     = 5'h05;
  localparam logic [OP_W-1:0] CARRY_SET_OP           = 5'h06;
  localparam logic [OP_W-1:0] CARRY_CLEAR_OP         = 5'h07;
  localparam logic [OP_W-1:0] NEGATIVE_SET_OP        = 5'h08;
  localparam logic [OP_W-1:0] NEGATIVE_CLEAR_OP      = 5'h09;
  localparam logic [OP_W-1:0] ZERO_SET_OP            = 5'h0a;
  localparam logic [OP_W-1:0] ZERO_CLEAR_OP          = 5'h0b;
  localparam logic [OP_W-1:0] GLOBAL_IRQ_ENABLE_OP   = 5'h0c;
  localparam logic [OP_W-1:0] GLOBAL_IRQ_DISABLE_OP  = 5'h0d;
  localparam logic [OP_W-1:0] SIGN_SET_OP            = 5'h0e;
  localparam logic [OP_W-1:0] SIGN_CLEAR_OP          = 5'h0f;
  localparam logic [OP_W-1:0] OVERFLOW_SET_OP        = 5'h10;
  localparam logic [OP_W-1:0] OVERFLOW_CLEAR_OP      = 5'h11;
  localparam logic [OP_W-1:0] TRANSFER_BIT_SET_OP    = 5'h12;
  localparam logic [OP_W-1:0] TRANSFER_BIT_CLEAR_OP  = 5'h13;
  localparam logic [OP_W-1:0] HALF_CARRY_SET_OP      = 5'h14;
  localparam logic [OP_W-1:0] HALF_CARRY_CLEAR_OP    = 5'h15;

  // ===========================================================================
  // bus responses and channel states
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef enum logic [1:0] {WS_COLLECT = 2'b01, WS_RESP = 2'b10} sfbu_wr_state_type;
  typedef enum logic [1:0] {RS_ADDR = 2'b01, RS_DATA = 2'b10} sfbu_rd_state_type;

endpackage : sfbu_pkg

// File: hw/sfbu_data_ops.sv
// register data path: shift right, nibble swap and transfer-bit load
`timescale 1ns/1ns
module sfbu_data_ops (
  input  wire logic [sfbu_pkg::OP_W-1:0]  op,
  input  wire logic [sfbu_pkg::IDX_W-1:0] bit_idx,
  input  wire logic [sfbu_pkg::REG_W-1:0] dest,
  input  wire logic                       t_bit,
  output logic      [sfbu_pkg::REG_W-1:0] result,
  output logic                            asr_c,
  output logic                            asr_z,
  output logic                            asr_n,
  output logic                            asr_v
);
  import sfbu_pkg::*;

  logic [REG_W-1:0] shifted;

  // ===========================================================================
  // shift: each bit takes its upper neighbour, top bit keeps the sign
  genvar g;
  generate
    for (g = 0; g < REG_W - 1; g++) begin : g_shift
      assign shifted[g] = dest[g+1];                                 // [RULE_01]
    end
  endgenerate
  assign shifted[REG_W-1] = dest[REG_W-1];                          // [RULE_15]

  always_comb begin
    result = dest;
    asr_c  = dest[0];                                                // [RULE_01]
    asr_n  = shifted[REG_W-1];
    asr_z  = (shifted == '0);
    asr_v  = asr_n ^ asr_c;
    case (op)
      ARITH_SHIFT_RIGHT_OP: result = shifted;                        // [RULE_01]
      NIBBLE_SWAP_OP:       result = {dest[3:0], dest[7:4]};         // [RULE_02]
      TRANSFER_TO_BIT_OP:   result[bit_idx] = t_bit;                 // [RULE_05]
      default:              result = dest;
    endcase
  end

endmodule : sfbu_data_ops

// File: hw/sfbu_flag_ops.sv
// next value of the status flags for every operation of the unit
`timescale 1ns/1ns
module sfbu_flag_ops (
  input  wire logic [sfbu_pkg::OP_W-1:0]  op,
  input  wire logic [sfbu_pkg::IDX_W-1:0] bit_idx,
  input  wire logic [sfbu_pkg::REG_W-1:0] flags,
  input  wire logic [sfbu_pkg::REG_W-1:0] src,
  input  wire logic                       asr_c,
  input  wire logic                       asr_z,
  input  wire logic                       asr_n,
  input  wire logic                       asr_v,
  output logic      [sfbu_pkg::REG_W-1:0] next_flags,
  output logic                            legal
);
  import sfbu_pkg::*;

  always_comb begin
    next_flags = flags;
    legal      = 1'b1;
    case (op)
      ARITH_SHIFT_RIGHT_OP: begin
        next_flags[FLAG_Z] = asr_z;                                  // [RULE_01]
        next_flags[FLAG_C] = asr_c;
        next_flags[FLAG_N] = asr_n;
        next_flags[FLAG_V] = asr_v;
      end
      NIBBLE_SWAP_OP, TRANSFER_TO_BIT_OP: next_flags = flags;        // [RULE_05]
      FLAG_SET_BY_INDEX_OP:   next_flags[bit_idx] = 1'b1;            // [RULE_03]
      FLAG_CLEAR_BY_INDEX_OP: next_flags[bit_idx] = 1'b0;            // [RULE_03]
      BIT_TO_TRANSFER_OP:     next_flags[FLAG_T] = src[bit_idx];     // [RULE_04]
      CARRY_SET_OP:           next_flags[FLAG_C] = 1'b1;             // [RULE_06]
      CARRY_CLEAR_OP:         next_flags[FLAG_C] = 1'b0;             // [RULE_06]
      NEGATIVE_SET_OP:        next_flags[FLAG_N] = 1'b1;             // [RULE_07]
      NEGATIVE_CLEAR_OP:      next_flags[FLAG_N] = 1'b0;             // [RULE_07]
      ZERO_SET_OP:            next_flags[FLAG_Z] = 1'b1;             // [RULE_08]
      ZERO_CLEAR_OP:          next_flags[FLAG_Z] = 1'b0;             // [RULE_08]
      GLOBAL_IRQ_ENABLE_OP:   next_flags[FLAG_I] = 1'b1;             // [RULE_09]
      GLOBAL_IRQ_DISABLE_OP:  next_flags[FLAG_I] = 1'b0;             // [RULE_09]
      SIGN_SET_OP:            next_flags[FLAG_S] = 1'b1;             // [RULE_10]
      SIGN_CLEAR_OP:          next_flags[FLAG_S] = 1'b0;             // [RULE_10]
      OVERFLOW_SET_OP:        next_flags[FLAG_V] = 1'b1;             // [RULE_11]
      OVERFLOW_CLEAR_OP:      next_flags[FLAG_V] = 1'b0;             // [RULE_11]
      TRANSFER_BIT_SET_OP:    next_flags[FLAG_T] = 1'b1;             // [RULE_12]
      TRANSFER_BIT_CLEAR_OP:  next_flags[FLAG_T] = 1'b0;             // [RULE_12]
      HALF_CARRY_SET_OP:      next_flags[FLAG_H] = 1'b1;             // [RULE_13]
      HALF_CARRY_CLEAR_OP:    next_flags[FLAG_H] = 1'b0;             // [RULE_13]
      default:                legal = 1'b0;
    endcase
  end

endmodule : sfbu_flag_ops

// File: hw/sfbu_top.sv
// status flag and bit operation unit with its register slave
//
// Notes on behaviour
// RULE_01 - Shift right moves bits 7..1 down into 6..0 and updates zero, carry, negative and overflow.
// RULE_02 - Nibble swap exchanges the low and high four bits of the destination in one step.
// RULE_03 - Indexed flag set or clear drives the selected status bit to one or zero, others untouched.
// RULE_04 - Bit store copies the selected source bit into the transfer flag and touches no other flag.
// RULE_05 - Bit load writes the transfer flag into the selected destination bit, keeping other bits and all flags.
// RULE_06 - Carry set and clear force only the carry flag.
// RULE_07 - Negative set and clear force only the negative flag.
// RULE_08 - Zero set and clear force only the zero flag.
// RULE_09 - Interrupt enable sets and disable clears only the global interrupt flag.
// RULE_10 - Sign set and clear force only the sign flag.
// RULE_11 - Overflow set and clear force only the overflow flag.
// RULE_12 - Transfer set and clear force only the transfer flag.
// RULE_13 - Half-carry set and clear force only the half-carry flag.
// RULE_14 - Each operation finishes in one clock and its result is seen by the very next operation.
// RULE_15 - Shift right keeps the top bit of the destination so the sign survives.
`timescale 1ns/1ns
module sfbu_top (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // write address channel
  input  wire logic [sfbu_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]                    awprot,
  input  wire logic                          awvalid,
  output logic                               awready,
  // write data channel
  input  wire logic [sfbu_pkg::DATA_W-1:0]   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  // write response channel
  output logic      [1:0]                    bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // read address channel
  input  wire logic [sfbu_pkg::ADDR_W-1:0]   araddr,
  input  wire logic [2:0]                    arprot,
  input  wire logic                          arvalid,
  output logic                               arready,
  // read data channel
  output logic      [sfbu_pkg::DATA_W-1:0]   rdata,
  output logic      [1:0]                    rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // core-facing state
  output logic      [sfbu_pkg::REG_W-1:0]    status_flags_register,
  output logic      [sfbu_pkg::REG_W-1:0]    dest_register
);
  import sfbu_pkg::*;

  // ===========================================================================
  // declarations
  sfbu_wr_state_type    wstate;
  sfbu_wr_state_type    next_wstate;
  sfbu_rd_state_type    rstate;
  sfbu_rd_state_type    next_rstate;

  logic                 next_awready;
  logic                 next_wready;
  logic [1:0]           next_bresp;
  logic                 next_bvalid;
  logic [ADDR_W-1:0]    waddr_q;
  logic [ADDR_W-1:0]    next_waddr_q;
  logic [DATA_W-1:0]    wdata_q;
  logic [DATA_W-1:0]    next_wdata_q;
  logic [3:0]           wstrb_q;
  logic [3:0]           next_wstrb_q;
  logic                 wr_commit;

  logic                 next_arready;
  logic [DATA_W-1:0]    next_rdata;
  logic [1:0]           next_rresp;
  logic                 next_rvalid;

  logic [REG_W-1:0]     next_flags;
  logic [REG_W-1:0]     next_dest;
  logic [REG_W-1:0]     src_register;
  logic [REG_W-1:0]     next_src;
  logic [OP_W-1:0]      cmd_op;
  logic [OP_W-1:0]      next_cmd_op;
  logic [IDX_W-1:0]     cmd_idx;
  logic [IDX_W-1:0]     next_cmd_idx;
  logic [CNT_W-1:0]     op_count;
  logic [CNT_W-1:0]     next_op_count;
  logic                 op_illegal;
  logic                 next_op_illegal;

  logic [OP_W-1:0]      exec_op;
  logic [IDX_W-1:0]     exec_idx;
  logic [REG_W-1:0]     alu_result;
  logic [REG_W-1:0]     alu_flags;
  logic                 alu_legal;
  logic                 asr_c;
  logic                 asr_z;
  logic                 asr_n;
  logic                 asr_v;
  logic                 exec_go;

  // ===========================================================================
  // address decode
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'b00};
    addr_mapped = (w == CMD_OFS) || (w == DEST_OFS) || (w == SRC_OFS) ||
                  (w == FLAGS_OFS) || (w == STAT_OFS);
  endfunction : addr_mapped

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    addr_is = ({a[ADDR_W-1:2], 2'b00} == ofs);
  endfunction : addr_is

  // ===========================================================================
  // write channel: address and data taken in either order
  always_comb begin
    next_wstate  = wstate;
    next_awready = awready;
    next_wready  = wready;
    next_waddr_q = waddr_q;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    wr_commit    = 1'b0;
    case (wstate)
      WS_COLLECT: begin
        if (awvalid && awready) begin
          next_waddr_q = awaddr;
          next_awready = 1'b0;
        end
        if (wvalid && wready) begin
          next_wdata_q = wdata;
          next_wstrb_q = wstrb;
          next_wready  = 1'b0;
        end
        // both halves held: commit now, answer on the next edge
        if (!awready && !wready) begin
          wr_commit   = 1'b1;
          next_bvalid = 1'b1;
          next_bresp  = addr_mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
          next_wstate = WS_RESP;
        end
      end
      WS_RESP: begin
        if (bready) begin
          next_bvalid  = 1'b0;
          next_awready = 1'b1;
          next_wready  = 1'b1;
          next_wstate  = WS_COLLECT;
        end
      end
      default: begin
        next_wstate  = WS_COLLECT;
        next_awready = 1'b1;
        next_wready  = 1'b1;
        next_bvalid  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate  <= WS_COLLECT;
      awready <= 1'b1;
      wready  <= 1'b1;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      wstate  <= next_wstate;
      awready <= next_awready;
      wready  <= next_wready;
      waddr_q <= next_waddr_q;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
    end
  end

  // ===========================================================================
  // operation datapath
  assign exec_op  = wdata_q[CMD_OP_LSB +: OP_W];
  assign exec_idx = wdata_q[CMD_IDX_LSB +: IDX_W];
  assign exec_go  = wr_commit && addr_is(waddr_q, CMD_OFS) && wstrb_q[0];

  sfbu_data_ops u_data_ops (
    .op      (exec_op),
    .bit_idx (exec_idx),
    .dest    (dest_register),
    .t_bit   (status_flags_register[FLAG_T]),
    .result  (alu_result),
    .asr_c   (asr_c),
    .asr_z   (asr_z),
    .asr_n   (asr_n),
    .asr_v   (asr_v)
  );

  sfbu_flag_ops u_flag_ops (
    .op         (exec_op),
    .bit_idx    (exec_idx),
    .flags      (status_flags_register),
    .src        (src_register),
    .asr_c      (asr_c),
    .asr_z      (asr_z),
    .asr_n      (asr_n),
    .asr_v      (asr_v),
    .next_flags (alu_flags),
    .legal      (alu_legal)
  );

  // ===========================================================================
  // architectural state: operands, flags, command record
  always_comb begin
    next_dest       = dest_register;
    next_src        = src_register;
    next_flags      = status_flags_register;
    next_cmd_op     = cmd_op;
    next_cmd_idx    = cmd_idx;
    next_op_count   = op_count;
    next_op_illegal = op_illegal;
    if (exec_go) begin
      next_cmd_op  = exec_op;
      next_cmd_idx = exec_idx;
      // unknown codes leave operands and flags alone
      if (alu_legal) begin
        next_dest       = alu_result;                                // [RULE_14]
        next_flags      = alu_flags;                                 // [RULE_14]
        next_op_count   = op_count + 16'h0001;
        next_op_illegal = 1'b0;
      end else begin
        next_op_illegal = 1'b1;
      end
    end else if (wr_commit && wstrb_q[0]) begin
      if (addr_is(waddr_q, DEST_OFS)) begin
        next_dest = wdata_q[REG_W-1:0];
      end
      if (addr_is(waddr_q, SRC_OFS)) begin
        next_src = wdata_q[REG_W-1:0];
      end
      if (addr_is(waddr_q, FLAGS_OFS)) begin
        next_flags = wdata_q[REG_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dest_register         <= DEST_RST;
      src_register          <= SRC_RST;
      status_flags_register <= FLAGS_RST;
      cmd_op                <= OP_RST;
      cmd_idx               <= '0;
      op_count              <= CNT_RST;
      op_illegal            <= 1'b0;
    end else begin
      dest_register         <= next_dest;
      src_register          <= next_src;
      status_flags_register <= next_flags;
      cmd_op                <= next_cmd_op;
      cmd_idx               <= next_cmd_idx;
      op_count              <= next_op_count;
      op_illegal            <= next_op_illegal;
    end
  end

  // ===========================================================================
  // read channel: data sampled when the address is taken
  always_comb begin
    next_rstate  = rstate;
    next_arready = arready;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_rvalid  = rvalid;
    case (rstate)
      RS_ADDR: begin
        if (arvalid && arready) begin
          next_arready = 1'b0;
          next_rvalid  = 1'b1;
          next_rresp   = addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
          next_rdata   = '0;
          if (addr_is(araddr, CMD_OFS)) begin
            next_rdata[CMD_OP_LSB +: OP_W]   = cmd_op;
            next_rdata[CMD_IDX_LSB +: IDX_W] = cmd_idx;
          end
          if (addr_is(araddr, DEST_OFS)) begin
            next_rdata[REG_W-1:0] = dest_register;
          end
          if (addr_is(araddr, SRC_OFS)) begin
            next_rdata[REG_W-1:0] = src_register;
          end
          if (addr_is(araddr, FLAGS_OFS)) begin
            next_rdata[REG_W-1:0] = status_flags_register;
          end
          if (addr_is(araddr, STAT_OFS)) begin
            next_rdata[CNT_W-1:0]   = op_count;
            next_rdata[STAT_ILL_BIT] = op_illegal;
          end
          next_rstate = RS_DATA;
        end
      end
      RS_DATA: begin
        if (rready) begin
          next_rvalid  = 1'b0;
          next_arready = 1'b1;
          next_rstate  = RS_ADDR;
        end
      end
      default: begin
        next_rstate  = RS_ADDR;
        next_arready = 1'b1;
        next_rvalid  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstate  <= RS_ADDR;
      arready <= 1'b1;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
    end else begin
      rstate  <= next_rstate;
      arready <= next_arready;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      rvalid  <= next_rvalid;
    end
  end

endmodule : sfbu_top

// File: sim/sfbu_checker.sv
// concurrent checks on bus timing and operation results of the flag unit
`timescale 1ns/1ns
module sfbu_checker (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic [sfbu_pkg::ADDR_W-1:0] awaddr,
  input wire logic                        awvalid,
  input wire logic                        awready,
  input wire logic [sfbu_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0]                  wstrb,
  input wire logic                        wvalid,
  input wire logic                        wready,
  input wire logic                        bvalid,
  input wire logic                        arvalid,
  input wire logic                        arready,
  input wire logic                        rvalid,
  input wire logic [sfbu_pkg::REG_W-1:0]  status_flags_register,
  input wire logic [sfbu_pkg::REG_W-1:0]  dest_register
);
  import sfbu_pkg::*;
  // ===========================================================================
  // sequences
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  // only commands whose address and data are taken together are tracked
  sequence s_cmd(logic [OP_W-1:0] op);
    s_wr_take ##0 (awaddr == CMD_OFS && wstrb[0] && wdata[OP_W-1:0] == op);
  endsequence
  // ===========================================================================
  // properties
  a_wr_answer: assert property (s_wr_take |=> !bvalid ##1 bvalid)
    else $error("write answer not two cycles after take");
  a_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_flags_quiet: assert property ($changed(status_flags_register) |-> $rose(bvalid))
    else $error("flags moved outside a write commit");
  a_dest_quiet: assert property ($changed(dest_register) |-> $rose(bvalid))
    else $error("destination moved outside a write commit");
  a_carry_set: assert property (s_cmd(CARRY_SET_OP) |-> ##2
    status_flags_register == ($past(status_flags_register, 2) | 8'h01))
    else $error("carry set result wrong");
  a_irq_clear: assert property (s_cmd(GLOBAL_IRQ_DISABLE_OP) |-> ##2
    status_flags_register == ($past(status_flags_register, 2) & 8'h7f))
    else $error("interrupt disable result wrong");
  a_swap_nibbles: assert property (s_cmd(NIBBLE_SWAP_OP) |-> ##2
    dest_register == {$past(dest_register[3:0], 2), $past(dest_register[7:4], 2)})
    else $error("nibble swap result wrong");
  a_shift_sign: assert property (s_cmd(ARITH_SHIFT_RIGHT_OP) |-> ##2
    dest_register == {$past(dest_register[7], 2), $past(dest_register[7:1], 2)})
    else $error("shift right result wrong");
endmodule : sfbu_checker

bind sfbu_top sfbu_checker u_chk (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
  .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .status_flags_register(status_flags_register),
  .dest_register(dest_register));

// File: sim/tb_status_flag_bit_ops_unit.sv
// self-checking bench for the flag unit driven over its register bus
`timescale 1ns/1ns
module tb_status_flag_bit_ops_unit;
  import sfbu_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, flags, dest, exp_f, d;
  logic [2:0]  prot = 3'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, resp;
  int          failures = 0, comparisons = 0, legal_ops = 0;
  int          pos[8] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S, FLAG_V, FLAG_T, FLAG_H};
  logic [7:0]  asr_in[3] = '{8'h81, 8'h01, 8'h7e};

  always #2 aclk = ~aclk;

  sfbu_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(prot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(prot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .status_flags_register(flags),
    .dest_register(dest));

  // ===========================================================================
  // reporting
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask : chk_resp

  // ===========================================================================
  // bus master: requests held until taken, every wait bounded
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && !(bready && bvalid); n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    if (n == 50) chk(32'h0, 32'h1);
    if (n == 50) summarize();
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && !(rready && rvalid); n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    if (n == 50) chk(32'h0, 32'h1);
    if (n == 50) summarize();
    chk(rdata, exp);
    chk_resp(rresp, exp_resp);
    rready <= 1'b0;
  endtask : rd_chk

  task automatic exec(input logic [OP_W-1:0] op, input logic [2:0] idx);
    wr(CMD_OFS, {21'h0, idx, 3'h0, op});
    chk_resp(resp, RESP_OKAY);
    if (op <= HALF_CARRY_CLEAR_OP) legal_ops++;
  endtask : exec

  // ===========================================================================
  // scenarios
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(CMD_OFS, {27'h0, OP_RST}, RESP_OKAY);
    rd_chk(FLAGS_OFS, 32'h0, RESP_OKAY);
    rd_chk(DEST_OFS, 32'h0, RESP_OKAY);
    rd_chk(SRC_OFS, 32'h0, RESP_OKAY);
    // opposite background so a stray change to any other flag shows
    for (int k = 0; k < 16; k++) begin
      wr(FLAGS_OFS, k[0] ? 32'hff : 32'h00);
      exec(CARRY_SET_OP + k[4:0], 3'h0);
      exp_f = 8'h01 << pos[k/2];
      // xor keeps the expectation 8 bits wide inside the 32-bit compare
      chk(flags, exp_f ^ {8{k[0]}});
    end
    wr(FLAGS_OFS, 32'h0);
    exp_f = 8'h00;
    for (int i = 0; i < 16; i++) begin
      exec(i < 8 ? FLAG_SET_BY_INDEX_OP : FLAG_CLEAR_BY_INDEX_OP, i[2:0]);
      exp_f[i[2:0]] = (i < 8);
      chk(flags, exp_f);
    end
    wr(SRC_OFS, 32'h04);
    wr(DEST_OFS, 32'h00);
    wr(FLAGS_OFS, 32'hbf);
    exec(BIT_TO_TRANSFER_OP, 3'h2);
    chk(flags, 8'hff);
    exec(TRANSFER_TO_BIT_OP, 3'h5);
    chk(dest, 8'h20);
    chk(flags, 8'hff);
    exec(BIT_TO_TRANSFER_OP, 3'h3);
    chk(flags, 8'hbf);
    wr(DEST_OFS, 32'hff);
    exec(TRANSFER_TO_BIT_OP, 3'h0);
    chk(dest, 8'hfe);
    foreach (asr_in[j]) begin
      wr(FLAGS_OFS, 32'h70);
      wr(DEST_OFS, {24'h0, asr_in[j]});
      exec(ARITH_SHIFT_RIGHT_OP, 3'h0);
      d = {asr_in[j][7], asr_in[j][7:1]};
      chk(dest, d);
      chk(flags, {4'h7, d[7] ^ asr_in[j][0], d[7], d == 8'h00, asr_in[j][0]});
    end
    wr(DEST_OFS, 32'ha5);
    wr(FLAGS_OFS, 32'h33);
    exec(NIBBLE_SWAP_OP, 3'h0);
    chk(dest, 8'h5a);
    chk(flags, 8'h33);
    // a write without the low byte lane must store nothing
    wstrb <= 4'he;
    wr(FLAGS_OFS, 32'h00);
    chk_resp(resp, RESP_OKAY);
    chk(flags, 8'h33);
    wstrb <= 4'hf;
    // an unknown opcode must leave state alone and be flagged
    exec(5'h1a, 3'h0);
    chk(flags, 8'h33);
    rd_chk(STAT_OFS, {15'h0, 1'b1, legal_ops[15:0]}, RESP_OKAY);
    wr(8'h20, 32'hff);
    chk_resp(resp, RESP_SLVERR);
    rd_chk(8'h20, 32'h0, RESP_SLVERR);
    summarize();
  end
endmodule : tb_status_flag_bit_ops_unit
